// >>> common/output_macrocell_pkg.sv
package output_macrocell_pkg;

   localparam int NUM_CELLS = 10;
   localparam int TOTAL_TERMS = 120;
   localparam int MAX_TERMS = 16;

   // logic terms per cell, pairs of equal size mirrored around the array middle
   localparam int CELL_TERMS [NUM_CELLS] = '{8, 10, 12, 14, 16, 16, 14, 12, 10, 8};

   // configuration bit encodings
   localparam logic POL_TRUE = 1'b1;
   localparam logic POL_INVERT = 1'b0;
   localparam logic MODE_REGISTERED = 1'b0;
   localparam logic MODE_COMBINATORIAL = 1'b1;

   // flip-flop values forced by the shared terms and by srst
   localparam logic CLEAR_VALUE = 1'b0;
   localparam logic SET_VALUE = 1'b1;
   localparam logic RESET_VALUE = 1'b0;

   typedef enum logic [1:0] {
      OE_ALWAYS_ON,
      OE_ALWAYS_OFF,
      OE_FROM_TERM
   } oe_mode_t;

   function automatic int termOffset(input int k);
      int s;
      s = 0;
      for (int i = 0; i < k; i++) begin
         s = s + CELL_TERMS[i];
      end
      return s;
   endfunction

endpackage

// >>> core/macrocell_flop.sv
`timescale 1ns/1ps

module macrocell_flop (
   input wire logic clk,
   input wire logic srst,
   input wire logic clearTerm,
   input wire logic setTerm,
   input wire logic dIn,
   output logic qOut
);

   logic qReg;
   logic qNext;

   // set beats data; clear is asynchronous and beats both
   assign qNext = srst ? output_macrocell_pkg::RESET_VALUE :
                  setTerm ? output_macrocell_pkg::SET_VALUE : dIn;

   always_ff @(posedge clk or posedge clearTerm) begin
      if (clearTerm) begin
         qReg <= output_macrocell_pkg::CLEAR_VALUE;
      end else begin
         qReg <= qNext;
      end
   end

   assign qOut = qReg;

endmodule

// >>> core/output_macrocell_array.sv
`timescale 1ns/1ps

// Function
// - ten cells with 8, 10, 12, 14, 16 logic terms, two cells each
// - each cell has one extra product term only for output enable
// - per-cell output polarity true or inverting, in both modes
// - one async clear term and one sync set term shared by registered cells
// - clear term true forces every flip-flop to zero without a clock
// - set term true loads one into every flip-flop at next rising edge, unless clear or srst is true
// - clear and set act on flop state, pin level follows chosen polarity
// - two configuration bits per cell choose mode and polarity
// - registered pin driven from flop true output through polarity buffer
// - registered output enable equals the cell's own enable term
// - registered feedback is inverted flop output, true and complement offered
// - registered pin is output only, feedback never comes from the pin
// - combinatorial pin driven by the OR sum through polarity buffer
// - combinatorial enable always on, always off, or from enable term
// - combinatorial feedback taken from pin, true and complement offered
module output_macrocell_array (
   input wire logic clk,
   input wire logic srst,
   input wire logic [output_macrocell_pkg::TOTAL_TERMS-1:0] logicTerms,
   input wire logic [output_macrocell_pkg::NUM_CELLS-1:0] oeTerms,
   input wire logic sharedAsyncClearTerm,
   input wire logic sharedSyncSetTerm,
   input wire logic [output_macrocell_pkg::NUM_CELLS-1:0] macrocellCfgBitZero,
   input wire logic [output_macrocell_pkg::NUM_CELLS-1:0] macrocellCfgBitOne,
   input wire output_macrocell_pkg::oe_mode_t combOeMode [output_macrocell_pkg::NUM_CELLS],
   input wire logic [output_macrocell_pkg::NUM_CELLS-1:0] pinIn,
   output logic [output_macrocell_pkg::NUM_CELLS-1:0] pinOut,
   output logic [output_macrocell_pkg::NUM_CELLS-1:0] pinOe,
   output logic [output_macrocell_pkg::NUM_CELLS-1:0] feedbackTrue,
   output logic [output_macrocell_pkg::NUM_CELLS-1:0] feedbackComp
);

   ////////////////////////////////////////////////////////////////////////////
   // elaboration checks on the term layout

   if (output_macrocell_pkg::termOffset(output_macrocell_pkg::NUM_CELLS) != output_macrocell_pkg::TOTAL_TERMS) begin : g_bad_total
      $error("term counts do not add up to the term bus width");
   end

   for (genvar c = 0; c < output_macrocell_pkg::NUM_CELLS; c++) begin : g_check
      // sizes must come in equal pairs mirrored around the middle
      if (output_macrocell_pkg::CELL_TERMS[c] != output_macrocell_pkg::CELL_TERMS[output_macrocell_pkg::NUM_CELLS-1-c])
      begin : g_bad_pair
         $error("cell term counts are not paired");
      end
      if (output_macrocell_pkg::CELL_TERMS[c] < 1 || output_macrocell_pkg::CELL_TERMS[c] > output_macrocell_pkg::MAX_TERMS)
      begin : g_bad_size
         $error("cell term count out of range");
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // per-cell datapath

   logic [output_macrocell_pkg::NUM_CELLS-1:0] sumTerm;
   logic [output_macrocell_pkg::NUM_CELLS-1:0] flopQ;
   logic [output_macrocell_pkg::NUM_CELLS-1:0] isComb;
   logic [output_macrocell_pkg::NUM_CELLS-1:0] isTrue;
   logic [output_macrocell_pkg::NUM_CELLS-1:0] cellValue;
   logic [output_macrocell_pkg::NUM_CELLS-1:0] combOe;

   for (genvar c = 0; c < output_macrocell_pkg::NUM_CELLS; c++) begin : g_cell
      localparam int OFS = output_macrocell_pkg::termOffset(c);
      localparam int NT = output_macrocell_pkg::CELL_TERMS[c];

      wire logic [NT-1:0] cellTerms;

      assign cellTerms = logicTerms[OFS +: NT];
      assign sumTerm[c] = |cellTerms;

      assign isComb[c] = (macrocellCfgBitOne[c] == output_macrocell_pkg::MODE_COMBINATORIAL);
      assign isTrue[c] = (macrocellCfgBitZero[c] == output_macrocell_pkg::POL_TRUE);

      // flop also runs in combinatorial mode; its state is simply unused there
      macrocell_flop u_flop (
         .clk(clk),
         .srst(srst),
         .clearTerm(sharedAsyncClearTerm),
         .setTerm(sharedSyncSetTerm),
         .dIn(sumTerm[c]),
         .qOut(flopQ[c])
      );

      // polarity is applied after the flop, so clear and set ignore it
      assign cellValue[c] = isComb[c] ? sumTerm[c] : flopQ[c];
      assign pinOut[c] = isTrue[c] ? cellValue[c] : ~cellValue[c];

      assign combOe[c] = (combOeMode[c] == output_macrocell_pkg::OE_ALWAYS_ON) ? 1'b1 :
                         (combOeMode[c] == output_macrocell_pkg::OE_FROM_TERM) ? oeTerms[c] :
                         1'b0;
      assign pinOe[c] = isComb[c] ? combOe[c] : oeTerms[c];

      // registered cells never look at the pin, so they cannot act as inputs
      assign feedbackTrue[c] = isComb[c] ? pinIn[c] : ~flopQ[c];
      assign feedbackComp[c] = isComb[c] ? ~pinIn[c] : flopQ[c];

      /////////////////////////////////////////////////////////////////////////
      // checks

      sequence clearHeld;
         sharedAsyncClearTerm [*2];
      endsequence

      sequence setNoClear;
         sharedSyncSetTerm && !sharedAsyncClearTerm;
      endsequence

      a_clear_forces_zero: assert property (
         @(posedge clk) disable iff (srst)
         sharedAsyncClearTerm |-> (flopQ[c] == output_macrocell_pkg::CLEAR_VALUE))
         else $error("flop not zero while clear term true");

      a_set_loads_one: assert property (
         @(posedge clk) disable iff (srst)
         setNoClear |=> (flopQ[c] == output_macrocell_pkg::SET_VALUE) || sharedAsyncClearTerm)
         else $error("flop did not load one after set term");

      a_flop_captures_sum: assert property (
         @(posedge clk) disable iff (srst)
         (!sharedSyncSetTerm && !sharedAsyncClearTerm) |=>
            (flopQ[c] == $past(sumTerm[c])) || sharedAsyncClearTerm)
         else $error("flop did not capture the sum term");

      a_clear_pin_polarity: assert property (
         @(posedge clk) disable iff (srst)
         (clearHeld and (!isComb[c]) [*2]) |-> (pinOut[c] == ~isTrue[c]))
         else $error("cleared pin level does not follow polarity");

      a_reg_pin_value: assert property (
         @(posedge clk) disable iff (srst)
         (!isComb[c] && !sharedAsyncClearTerm && !sharedSyncSetTerm) ##1 !isComb[c] |->
            pinOut[c] == (isTrue[c] ? $past(sumTerm[c]) : ~$past(sumTerm[c])))
         else $error("registered pin does not show last captured sum");

      a_reg_oe_term: assert property (
         @(posedge clk) disable iff (srst)
         !isComb[c] |-> (pinOe[c] == oeTerms[c]))
         else $error("registered enable differs from enable term");

      a_comb_pin_value: assert property (
         @(posedge clk) disable iff (srst)
         isComb[c] |-> (pinOut[c] == (isTrue[c] ~^ sumTerm[c])))
         else $error("combinatorial pin does not follow sum term");

      a_comb_oe_modes: assert property (
         @(posedge clk) disable iff (srst)
         isComb[c] |-> (pinOe[c] ==
            ((combOeMode[c] == output_macrocell_pkg::OE_ALWAYS_ON) ||
             ((combOeMode[c] == output_macrocell_pkg::OE_FROM_TERM) && oeTerms[c]))))
         else $error("combinatorial enable mode wrong");

      a_reg_feedback: assert property (
         @(posedge clk) disable iff (srst)
         !isComb[c] |-> (feedbackTrue[c] == ~flopQ[c]) && (feedbackComp[c] == flopQ[c]))
         else $error("registered feedback not from flop");

      a_comb_feedback: assert property (
         @(posedge clk) disable iff (srst)
         isComb[c] |-> (feedbackTrue[c] == pinIn[c]) && (feedbackComp[c] != pinIn[c]))
         else $error("combinatorial feedback not from pin");
   end

   ////////////////////////////////////////////////////////////////////////////
   // shared terms reach every cell alike

   a_shared_clear_all: assert property (
      @(posedge clk) disable iff (srst)
      sharedAsyncClearTerm |-> (flopQ == '0))
      else $error("shared clear missed a cell");

   a_shared_set_all: assert property (
      @(posedge clk) disable iff (srst)
      (sharedSyncSetTerm && !sharedAsyncClearTerm) |=> (flopQ == '1) || sharedAsyncClearTerm)
      else $error("shared set missed a cell");

endmodule

// >>> test/tb.sv
`timescale 1ns/1ps
module tb;
   localparam int N = output_macrocell_pkg::NUM_CELLS;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic [output_macrocell_pkg::TOTAL_TERMS-1:0] logicTerms = '0;
   logic [N-1:0] oeTerms = '0;
   logic sharedAsyncClearTerm = 1'b0;
   logic sharedSyncSetTerm = 1'b0;
   logic [N-1:0] macrocellCfgBitZero = '1;
   logic [N-1:0] macrocellCfgBitOne = '0;
   output_macrocell_pkg::oe_mode_t combOeMode [N] = '{default: output_macrocell_pkg::OE_ALWAYS_ON};
   logic [N-1:0] pinIn = '0;
   logic [N-1:0] pinOut, pinOe, feedbackTrue, feedbackComp;
   int error_cnt = 0;
   int checks_done = 0;
   int cycleCnt = 0;
   // term counts kept here on purpose, independent of the package offsets
   int cellSize [N] = '{8, 10, 12, 14, 16, 16, 14, 12, 10, 8};
   output_macrocell_array i_output_macrocell_array (.clk(clk), .srst(srst),
      .logicTerms(logicTerms), .oeTerms(oeTerms), .sharedAsyncClearTerm(sharedAsyncClearTerm),
      .sharedSyncSetTerm(sharedSyncSetTerm), .macrocellCfgBitZero(macrocellCfgBitZero),
      .macrocellCfgBitOne(macrocellCfgBitOne), .combOeMode(combOeMode), .pinIn(pinIn),
      .pinOut(pinOut), .pinOe(pinOe), .feedbackTrue(feedbackTrue), .feedbackComp(feedbackComp));
   always #5 clk = ~clk;
   ////////////////////////////////////////////////////////////////////////////
   task automatic finish_test;
      $display("checks %0d, mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // hang guard, whole run needs well under 200 cycles
   always @(posedge clk) begin
      cycleCnt <= cycleCnt + 1;
      if (cycleCnt == 2000) begin
         error_cnt++;
         finish_test();
      end
   end
   task automatic chk(input logic [N-1:0] got, input logic [N-1:0] exp, input string msg);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: %s got %h exp %h", $time, msg, got, exp);
      end
   endtask
   task automatic step;
      @(posedge clk);
      #1;
   endtask
   // sets term t of cell c, offsets summed from the local size table
   task automatic setTerm(input int c, input int t);
      int o;
      o = 0;
      for (int i = 0; i < c; i++) o += cellSize[i];
      logicTerms[o + t] = 1'b1;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task automatic test_comb;
      logic [N-1:0] one;
      macrocellCfgBitOne = '1;
      for (int p = 0; p < 2; p++) begin
         for (int c = 0; c < N; c++) begin
            // every drive lands just after an edge, never on one
            step();
            macrocellCfgBitZero = p ? '1 : '0;
            one = '0;
            one[c] = 1'b1;
            logicTerms = '0;
            setTerm(c, cellSize[c] - 1);
            #1 chk(pinOut, p ? one : ~one, "comb last term");
         end
      end
      step();
      oeTerms = 10'h2a5;
      pinIn = 10'h1c3;
      combOeMode = '{default: output_macrocell_pkg::OE_ALWAYS_ON};
      #1 chk(pinOe, '1, "oe on");
      step();
      combOeMode = '{default: output_macrocell_pkg::OE_ALWAYS_OFF};
      #1 chk(pinOe, '0, "oe off");
      step();
      combOeMode = '{default: output_macrocell_pkg::OE_FROM_TERM};
      #1 chk(pinOe, 10'h2a5, "oe term");
      chk(feedbackTrue, 10'h1c3, "comb fb true");
      chk(feedbackComp, ~10'h1c3, "comb fb comp");
      // flops keep clocking in comb mode; leave them empty for the next test
      step();
      logicTerms = '0;
      $display("test_comb done");
   endtask
   task automatic test_reg;
      step();
      macrocellCfgBitOne = '0;
      macrocellCfgBitZero = 10'h155;
      logicTerms = '0;
      for (int c = 0; c < N; c++) if (10'h0f3 >> c & 1) setTerm(c, 0);
      oeTerms = 10'h13c;
      pinIn = 10'h3ff;
      #1 chk(feedbackComp, '0, "no capture before edge");
      step();
      chk(feedbackComp, 10'h0f3, "flop q");
      chk(feedbackTrue, ~10'h0f3, "flop nq");
      chk(pinOut, 10'h0f3 ~^ 10'h155, "reg pin");
      chk(pinOe, 10'h13c, "reg oe");
      $display("test_reg done");
   endtask
   task automatic test_set_clear;
      logicTerms = '0;
      sharedSyncSetTerm = 1'b1;
      #1 chk(feedbackComp, 10'h0f3, "set waits for edge");
      step();
      chk(feedbackComp, '1, "set all");
      sharedAsyncClearTerm = 1'b1;
      #1 chk(feedbackComp, '0, "clear at once");
      chk(pinOut, ~10'h155, "clear pin per polarity");
      step();
      chk(feedbackComp, '0, "clear beats set");
      // clear held over two edges so the pin polarity assertion is reached
      step();
      chk(pinOut, ~10'h155, "held clear pin per polarity");
      sharedAsyncClearTerm = 1'b0;
      srst = 1'b1;
      step();
      chk(feedbackComp, '0, "srst beats set");
      srst = 1'b0;
      sharedSyncSetTerm = 1'b0;
      $display("test_set_clear done");
   endtask
   initial begin
      repeat (20) @(posedge clk);
      #1 srst = 1'b0;
      test_comb();
      test_reg();
      test_set_clear();
      finish_test();
   end
endmodule
